// [analog_front_end_control_regs.sv]
/*
 Analog front end control register bank: gain register, bias and
 integrator reset register, and a read-only mirror of the gain register.
 Assumes a plain register port whose master never raises read and
 write strobes together, and a reset pin already synchronous to mclk.
*/
// The implementer's own choice: the address-and-strobe port.
// Functional notes
// - Both control registers go back to their defaults on power-on reset or on the reset pin.
// - Three single bits select unity or double gain for the three voltage inputs.
// - Four 3-bit codes pick current gain x2, x4, x16, or x32 for any other code.
// - The gain register is readable through a separate mirror register.
// - One bit raises the reference generator bias to one and a half times nominal.
// - One bit raises the reference buffer bias to 1.33 times nominal.
// - Two 2-bit codes trim the two ADC bias currents from nominal up to x2.5.
// - Integrator reset bits hold the modulators of three voltage and the neutral channel in reset while one.
`default_nettype none

module analog_front_end_control_regs
   import afe_ctrl_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rstPin_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [DATA_W-1:0] regRdata,
   output logic volt_a_gain_sel,
   output logic volt_b_gain_sel,
   output logic volt_c_gain_sel,
   output logic [2:0] current_a_gain_sel,
   output logic [2:0] current_b_gain_sel,
   output logic [2:0] current_c_gain_sel,
   output logic [2:0] neutral_current_gain_sel,
   output logic [7:0] currentGainStep,
   output logic ref_generator_bias_trim,
   output logic ref_buffer_bias_trim,
   output logic [1:0] adc_bias_trim_second,
   output logic [1:0] adc_bias_trim_first,
   output logic volt_a_integrator_reset,
   output logic volt_b_integrator_reset,
   output logic volt_c_integrator_reset,
   output logic neutral_integrator_reset
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   logic [DATA_W-1:0] gainCtrl_r;
   logic [DATA_W-1:0] gainCtrl_nxt;
   logic [DATA_W-1:0] biasCtrl_r;
   logic [DATA_W-1:0] biasCtrl_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [11:0] curCodes;
   logic [1:0] chStep [4];

   always_comb
   begin
      gainCtrl_nxt = gainCtrl_r;
      biasCtrl_nxt = biasCtrl_r;
      if (!rstPin_n)
      begin
         // Pin reset acts like power-on reset but on the clock
         gainCtrl_nxt = GAIN_CTRL_RST;
         biasCtrl_nxt = BIAS_CTRL_RST;
      end
      else if (regWrite)
      begin
         // Reserved bits are dropped so stray writes cannot reach the analog
         if (regAddr == GAIN_CTRL_OFS)
            gainCtrl_nxt = regWdata & GAIN_CTRL_MASK;
         if (regAddr == BIAS_CTRL_OFS)
            biasCtrl_nxt = regWdata & BIAS_CTRL_MASK;
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gainCtrl_r <= GAIN_CTRL_RST;
         biasCtrl_r <= BIAS_CTRL_RST;
      end
      else
      begin
         gainCtrl_r <= gainCtrl_nxt;
         biasCtrl_r <= biasCtrl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; unmapped addresses return zero

   always_comb
   begin
      rdata_nxt = '0;
      if (regRead)
      begin
         case (regAddr)
            GAIN_CTRL_OFS: rdata_nxt = gainCtrl_r;
            BIAS_CTRL_OFS: rdata_nxt = biasCtrl_r;
            GAIN_MIRROR_OFS: rdata_nxt = gainCtrl_r;
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_r <= '0;
      else
         rdata_r <= rdata_nxt;
   end

   assign regRdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Static analog control levels

   assign volt_a_gain_sel = gainCtrl_r[VOLT_A_GAIN_POS];
   assign volt_b_gain_sel = gainCtrl_r[VOLT_B_GAIN_POS];
   assign volt_c_gain_sel = gainCtrl_r[VOLT_C_GAIN_POS];
   assign current_a_gain_sel = gainCtrl_r[CUR_A_GAIN_POS +: CUR_GAIN_W];
   assign current_b_gain_sel = gainCtrl_r[CUR_B_GAIN_POS +: CUR_GAIN_W];
   assign current_c_gain_sel = gainCtrl_r[CUR_C_GAIN_POS +: CUR_GAIN_W];
   assign neutral_current_gain_sel = gainCtrl_r[NEUTRAL_GAIN_POS +: CUR_GAIN_W];
   assign ref_generator_bias_trim = biasCtrl_r[REF_GEN_TRIM_POS];
   assign ref_buffer_bias_trim = biasCtrl_r[REF_BUF_TRIM_POS];
   assign adc_bias_trim_second = biasCtrl_r[ADC_TRIM2_POS +: ADC_TRIM_W];
   assign adc_bias_trim_first = biasCtrl_r[ADC_TRIM1_POS +: ADC_TRIM_W];
   // Held until software writes zero or a reset clears it; there is no self-clearing pulse
   assign volt_a_integrator_reset = biasCtrl_r[VOLT_A_INT_RST_POS];
   assign volt_b_integrator_reset = biasCtrl_r[VOLT_B_INT_RST_POS];
   assign volt_c_integrator_reset = biasCtrl_r[VOLT_C_INT_RST_POS];
   assign neutral_integrator_reset = biasCtrl_r[NEUTRAL_INT_RST_POS];

   ////////////////////////////////////////////////////////////////////////////
   // Decoded current gain steps, channel order A, B, C, neutral

   assign curCodes = {neutral_current_gain_sel, current_c_gain_sel,
                      current_b_gain_sel, current_a_gain_sel};

   generate
      for (genvar ch = 0; ch < 4; ch++)
      begin : g_curGain
         current_gain_decode u_decode (
            .mclk(mclk),
            .reset_n(reset_n),
            .gainCode(curCodes[ch*3 +: 3]),
            .gainStep(chStep[ch])
         );
      end
   endgenerate

   // One slot per decoder keeps every output bit to a single driver
   assign currentGainStep = {chStep[3], chStep[2], chStep[1], chStep[0]};

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_pin_reset_defaults: assert property (
      !rstPin_n |=> (gainCtrl_r == GAIN_CTRL_RST) && (biasCtrl_r == BIAS_CTRL_RST)
         && !volt_a_integrator_reset && !ref_generator_bias_trim)
      else $error("pin reset did not restore defaults");

   a_volt_gain_write: assert property (
      rstPin_n && regWrite && (regAddr == GAIN_CTRL_OFS)
         |=> {volt_c_gain_sel, volt_b_gain_sel, volt_a_gain_sel} == $past(regWdata[18:16]))
      else $error("voltage gain select not taken from write");

   a_cur_gain_path: assert property (
      rstPin_n && regWrite && (regAddr == GAIN_CTRL_OFS) && (regWdata[2:0] > 3'h2)
         ##1 !regWrite |=> currentGainStep[1:0] == 2'h3)
      else $error("high current gain code did not select x32");

   a_mirror_read: assert property (
      regRead && (regAddr == GAIN_MIRROR_OFS) |=> regRdata == $past(gainCtrl_r))
      else $error("mirror read differs from gain register");

   a_reserved_zero: assert property (
      regRead && (regAddr == GAIN_CTRL_OFS) |=> (regRdata & ~GAIN_CTRL_MASK) == 32'h0)
      else $error("reserved gain bits read nonzero");

   a_ref_trims_write: assert property (
      rstPin_n && regWrite && (regAddr == BIAS_CTRL_OFS)
         |=> {ref_generator_bias_trim, ref_buffer_bias_trim} == $past(regWdata[13:12]))
      else $error("reference bias trims not taken from write");

   a_adc_trims_write: assert property (
      rstPin_n && regWrite && (regAddr == BIAS_CTRL_OFS)
         |=> {adc_bias_trim_second, adc_bias_trim_first} == $past(regWdata[11:8]))
      else $error("adc bias trims not taken from write");

   a_integ_reset_hold: assert property (
      rstPin_n && volt_c_integrator_reset && !(regWrite && (regAddr == BIAS_CTRL_OFS))
         |=> volt_c_integrator_reset)
      else $error("integrator reset dropped without a write");

   a_integ_reset_set: assert property (
      rstPin_n && regWrite && (regAddr == BIAS_CTRL_OFS) && regWdata[3]
         |=> neutral_integrator_reset)
      else $error("neutral integrator reset not set by write");

   a_integ_reset_write: assert property (
      rstPin_n && regWrite && (regAddr == BIAS_CTRL_OFS) |=> {volt_c_integrator_reset,
         volt_b_integrator_reset, volt_a_integrator_reset, neutral_integrator_reset} == $past(regWdata[6:3]))
      else $error("integrator resets not taken from write");

   a_bias_reserved_zero: assert property (
      regRead && (regAddr == BIAS_CTRL_OFS) |=> (regRdata & ~BIAS_CTRL_MASK) == 32'h0)
      else $error("reserved bias bits read nonzero");

   a_gain_reg_hold: assert property (
      rstPin_n && !(regWrite && (regAddr == GAIN_CTRL_OFS)) |=> $stable(gainCtrl_r))
      else $error("gain register changed without a write");

   a_bias_reg_hold: assert property (
      rstPin_n && !(regWrite && (regAddr == BIAS_CTRL_OFS)) |=> $stable(biasCtrl_r))
      else $error("bias register changed without a write");

   a_rdata_idle: assert property (
      !regRead |=> regRdata == 32'h0)
      else $error("read data present without a read");

endmodule // analog_front_end_control_regs

`default_nettype wire

// [afe_ctrl_pkg.sv]
/*
 Shared constants for the analog front end control register bank:
 register offsets, field positions, writable masks, reset values and
 the decoded current gain steps.
 Assumes a 16-bit word address and 32-bit register data.
*/
`default_nettype none

package afe_ctrl_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;

   // Register offsets as printed (word addresses)
   localparam logic [15:0] GAIN_CTRL_OFS = 16'h8000;
   localparam logic [15:0] BIAS_CTRL_OFS = 16'h8001;
   localparam logic [15:0] GAIN_MIRROR_OFS = 16'hEC01;

   // Reset values
   localparam logic [31:0] GAIN_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] BIAS_CTRL_RST = 32'h0000_0000;

   // Writable bits; everything else is reserved and reads zero
   localparam logic [31:0] GAIN_CTRL_MASK = 32'h0007_7777;
   localparam logic [31:0] BIAS_CTRL_MASK = 32'h0000_3F78;

   // Field positions in the gain register (LSB of each field)
   localparam int VOLT_A_GAIN_POS = 16;
   localparam int VOLT_B_GAIN_POS = 17;
   localparam int VOLT_C_GAIN_POS = 18;
   localparam int CUR_A_GAIN_POS = 0;
   localparam int CUR_B_GAIN_POS = 4;
   localparam int CUR_C_GAIN_POS = 8;
   localparam int NEUTRAL_GAIN_POS = 12;
   localparam int CUR_GAIN_W = 3;

   // Field positions in the bias and reset register
   localparam int REF_GEN_TRIM_POS = 13;
   localparam int REF_BUF_TRIM_POS = 12;
   localparam int ADC_TRIM2_POS = 10;
   localparam int ADC_TRIM1_POS = 8;
   localparam int ADC_TRIM_W = 2;
   localparam int NEUTRAL_INT_RST_POS = 3;
   localparam int VOLT_A_INT_RST_POS = 4;
   localparam int VOLT_B_INT_RST_POS = 5;
   localparam int VOLT_C_INT_RST_POS = 6;

   // Decoded current channel gain
   typedef enum logic [1:0] {
      GAIN_X2 = 2'h0,
      GAIN_X4 = 2'h1,
      GAIN_X16 = 2'h2,
      GAIN_X32 = 2'h3
   } gain_step_t;

   localparam logic [2:0] CODE_X2 = 3'h0;
   localparam logic [2:0] CODE_X4 = 3'h1;
   localparam logic [2:0] CODE_X16 = 3'h2;

endpackage

`default_nettype wire

// [current_gain_decode.sv]
/*
 Registered decoder from a 3-bit current channel gain code to the
 gain step driven into the programmable amplifier.
 Assumes mclk and an asynchronous active-low reset_n.
*/
`default_nettype none

module current_gain_decode
   import afe_ctrl_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [2:0] gainCode,
   output logic [1:0] gainStep
);

   gain_step_t step_r;
   gain_step_t step_nxt;

   always_comb
   begin
      case (gainCode)
         CODE_X2: step_nxt = GAIN_X2;
         CODE_X4: step_nxt = GAIN_X4;
         CODE_X16: step_nxt = GAIN_X16;
         default: step_nxt = GAIN_X32;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         step_r <= GAIN_X2;
      else
         step_r <= step_nxt;
   end

   assign gainStep = step_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_step_follows: assert property (
      ##1 (gainStep == (($past(gainCode) > CODE_X16) ? 2'h3 : $past(gainCode[1:0]))))
      else $error("gain step does not follow gain code");

endmodule // current_gain_decode

`default_nettype wire

// [tb.sv]
/*
 Self-checking bench for the analog front end control register bank.
 Assumes the design package, a 10 MHz mclk and a bus master that never stalls.
*/
`default_nettype none

module tb
   import afe_ctrl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk, reset_n, rstPin_n, regWrite, regRead, rdSeen;
   logic [15:0] regAddr;
   logic [31:0] regWdata, regRdata, gainExp, biasExp, d;
   logic volt_a_gain_sel, volt_b_gain_sel, volt_c_gain_sel;
   logic [2:0] current_a_gain_sel, current_b_gain_sel, current_c_gain_sel;
   logic [2:0] neutral_current_gain_sel;
   logic [7:0] currentGainStep;
   logic ref_generator_bias_trim, ref_buffer_bias_trim;
   logic [1:0] adc_bias_trim_second, adc_bias_trim_first;
   logic volt_a_integrator_reset, volt_b_integrator_reset;
   logic volt_c_integrator_reset, neutral_integrator_reset;
   logic [31:0] q[$];
   int badCount, testsRun, cycles;

   analog_front_end_control_regs uut (.mclk(mclk), .reset_n(reset_n), .rstPin_n(rstPin_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .volt_a_gain_sel(volt_a_gain_sel),
      .volt_b_gain_sel(volt_b_gain_sel), .volt_c_gain_sel(volt_c_gain_sel),
      .current_a_gain_sel(current_a_gain_sel), .current_b_gain_sel(current_b_gain_sel),
      .current_c_gain_sel(current_c_gain_sel),
      .neutral_current_gain_sel(neutral_current_gain_sel),
      .currentGainStep(currentGainStep), .ref_generator_bias_trim(ref_generator_bias_trim),
      .ref_buffer_bias_trim(ref_buffer_bias_trim),
      .adc_bias_trim_second(adc_bias_trim_second), .adc_bias_trim_first(adc_bias_trim_first),
      .volt_a_integrator_reset(volt_a_integrator_reset),
      .volt_b_integrator_reset(volt_b_integrator_reset),
      .volt_c_integrator_reset(volt_c_integrator_reset),
      .neutral_integrator_reset(neutral_integrator_reset));

   ////////////////////////////////////////////////////////////////////////////////
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reportAndStop;
      $display("Checks %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Strobes stay as set until the next access, so back-to-back cycles never double-drive
   task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [31:0] v);
      @(posedge mclk);
      regWrite <= w;
      regRead <= r;
      regAddr <= a;
      regWdata <= v;
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      acc(1'b0, 1'b1, a, 32'h0000_0000);
      q.push_back(e);
   endtask

   task automatic settle;
      acc(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      #1;
   endtask

   function automatic logic [1:0] step(input logic [2:0] c);
      return (c > 3'h3) ? 2'h3 : c[1:0];
   endfunction

   task automatic chkOuts;
      chk({9'h000, volt_c_gain_sel, volt_b_gain_sel, volt_a_gain_sel, neutral_current_gain_sel,
         current_c_gain_sel, current_b_gain_sel, current_a_gain_sel, currentGainStep},
         {9'h000, gainExp[18:16], gainExp[14:12], gainExp[10:8], gainExp[6:4], gainExp[2:0],
         step(gainExp[14:12]), step(gainExp[10:8]), step(gainExp[6:4]),
         step(gainExp[2:0])});
      chk({22'h000000, ref_generator_bias_trim, ref_buffer_bias_trim, adc_bias_trim_second,
         adc_bias_trim_first, volt_c_integrator_reset, volt_b_integrator_reset,
         volt_a_integrator_reset, neutral_integrator_reset},
         {22'h000000, biasExp[13:8], biasExp[6:3]});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Read data is only valid one cycle after the strobe; at other times it must be zero
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         badCount++;
         reportAndStop;
      end
      if (rdSeen && q.size() > 0)
         chk(regRdata, q.pop_front());
      else
         chk(regRdata, 32'h0000_0000);
      rdSeen = regRead & reset_n;
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {reset_n, rstPin_n, regWrite, regRead, rdSeen} = 5'h18;
      regAddr = 16'h0000;
      regWdata = 32'h0000_0000;
      {badCount, testsRun, cycles} = '0;
      gainExp = 32'h0000_0000;
      biasExp = 32'h0000_0000;
      d = $urandom(34);
      // Reset falls after time zero so the asynchronous branch cannot miss it
      #1;
      reset_n <= 1'b0;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      rd(GAIN_CTRL_OFS, 32'h0000_0000);
      rd(BIAS_CTRL_OFS, 32'h0000_0000);
      rd(GAIN_MIRROR_OFS, 32'h0000_0000);
      settle;
      chkOuts;
      for (int c = 0; c < 8; c++)
      begin
         d = $urandom;
         d[2:0] = c[2:0];
         d[6:4] = 3'h7 - c[2:0];
         d[10:8] = c[2:0] + 3'h3;
         d[14:12] = c[2:0] ^ 3'h5;
         gainExp = d & GAIN_CTRL_MASK;
         acc(1'b1, 1'b0, GAIN_CTRL_OFS, gainExp);
         rd(GAIN_CTRL_OFS, gainExp);
         rd(GAIN_MIRROR_OFS, gainExp);
         settle;
         chkOuts;
      end
      for (int i = 0; i < 4; i++)
      begin
         d = $urandom;
         d[13:12] = i[1:0];
         d[11:10] = i[1:0];
         d[9:8] = ~i[1:0];
         biasExp = d & BIAS_CTRL_MASK;
         acc(1'b1, 1'b0, BIAS_CTRL_OFS, biasExp);
         rd(BIAS_CTRL_OFS, biasExp);
         settle;
         chkOuts;
      end
      // Integrator resets are levels; nothing may clear them but a write or reset
      repeat (10) @(posedge mclk);
      #1;
      chkOuts;
      acc(1'b1, 1'b0, GAIN_MIRROR_OFS, $urandom);
      acc(1'b1, 1'b0, 16'h8003, $urandom);
      rd(16'h8003, 32'h0000_0000);
      rd(GAIN_CTRL_OFS, gainExp);
      rd(BIAS_CTRL_OFS, biasExp);
      acc(1'b1, 1'b0, GAIN_CTRL_OFS, GAIN_CTRL_MASK);
      rstPin_n <= 1'b0;
      acc(1'b1, 1'b0, BIAS_CTRL_OFS, BIAS_CTRL_MASK);
      gainExp = 32'h0000_0000;
      biasExp = 32'h0000_0000;
      rd(GAIN_CTRL_OFS, 32'h0000_0000);
      rd(BIAS_CTRL_OFS, 32'h0000_0000);
      settle;
      chkOuts;
      rstPin_n <= 1'b1;
      // Current gains at the top step, as wanted while waiting for line voltage
      gainExp = 32'h0007_3333;
      acc(1'b1, 1'b0, GAIN_CTRL_OFS, gainExp);
      d = $urandom | 32'h0000_0078;
      biasExp = d & BIAS_CTRL_MASK;
      acc(1'b1, 1'b0, BIAS_CTRL_OFS, biasExp);
      settle;
      chkOuts;
      reset_n <= 1'b0;
      gainExp = 32'h0000_0000;
      biasExp = 32'h0000_0000;
      #10;
      chkOuts;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(GAIN_CTRL_OFS, 32'h0000_0000);
      rd(BIAS_CTRL_OFS, 32'h0000_0000);
      settle;
      reportAndStop;
   end

endmodule // tb

`default_nettype wire
